// ==== dv/core_model.sv ====
`timescale 1ns/100ps
module core_model
   import lite_ctrl_pkg::*;
(
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             launch_request,
   input wire logic             arg_b_valid,
   input wire logic [ARG_W-1:0] arg_a,
   input wire logic [ARG_W-1:0] arg_b,
   output logic                 accepts_new_input,
   output logic                 function_complete,
   output logic                 core_quiescent,
   output logic                 arg_b_read,
   output logic [ARG_W-1:0]     arg_c_out,
   output logic                 arg_c_out_valid
);
   logic [1:0] st_reg;

   // ----------------
   // Run sequence
   // ----------------
   // Takes a launch, waits on argument b, then finishes; all pulses last one cycle.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_reg            <= 2'h0;
         accepts_new_input <= 1'b0;
         function_complete <= 1'b0;
         arg_b_read        <= 1'b0;
         arg_c_out_valid   <= 1'b0;
         arg_c_out         <= 8'h00;
      end
      else
      begin
         accepts_new_input <= st_reg == 2'h0 && launch_request;
         arg_b_read        <= st_reg == 2'h1 && arg_b_valid;
         function_complete <= st_reg == 2'h2;
         arg_c_out_valid   <= st_reg == 2'h2;
         if (st_reg == 2'h1)
            arg_c_out <= ARG_W'(arg_a + arg_b);
         case (st_reg)
            2'h0: if (launch_request) st_reg <= 2'h1;
            2'h1: if (arg_b_valid) st_reg <= 2'h2;
            default: st_reg <= 2'h0;
         endcase
      end
   end

   assign core_quiescent = st_reg == 2'h0;
endmodule // core_model

// ==== dv/lite_ctrl_sva.sv ====
`timescale 1ns/100ps
module lite_ctrl_sva
   import lite_ctrl_pkg::*;
(
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic              launch_request,
   input wire logic              function_complete,
   input wire logic              accepts_new_input,
   input wire logic              arg_b_valid,
   input wire logic              arg_b_read,
   input wire logic              interrupt
);
   // ----------------
   // Bus and core relations
   // ----------------
   default clocking dc @(posedge clk); endclocking
   default disable iff (!resetn);

   // A joined write is answered soon.
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   property p_r_lat; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   // A pending read answer blocks new addresses.
   property p_one_rd; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_one_rd: assert property (p_one_rd) else $error("second read taken");
   property p_rdata_w; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_rdata_w: assert property (p_rdata_w) else $error("upper read bits set");
   property p_vld_clr; arg_b_read |=> !arg_b_valid; endproperty
   a_vld_clr: assert property (p_vld_clr) else $error("valid kept after use");
   // The interrupt drops only after a write.
   property p_irq_hold; $fell(interrupt) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2); endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
   property p_irq_src;
      $rose(interrupt) |->
         $past(function_complete, 2) || $past(accepts_new_input, 2) || $past(s_axi_bvalid);
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("interrupt without event");
   property p_launch_hold; launch_request && !accepts_new_input |=> launch_request; endproperty
   a_launch_hold: assert property (p_launch_hold) else $error("launch dropped early");
   property p_auto; $rose(launch_request) |-> s_axi_bvalid || $past(function_complete); endproperty
   a_auto: assert property (p_auto) else $error("launch without cause");

   c_irq: cover property ($rose(interrupt));
   c_bread: cover property (arg_b_read);
   c_auto: cover property ($rose(launch_request) && $past(function_complete));
endmodule // lite_ctrl_sva

bind lite_control_slave lite_ctrl_sva chk_u (.*);

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import lite_ctrl_pkg::*;
   logic              clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic              s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]        s_axi_wstrb = 4'hf;
   logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic              launch_request, resume_request, function_complete, accepts_new_input;
   logic              core_quiescent, arg_b_valid, arg_b_read, arg_c_out_valid, interrupt;
   logic [ARG_W-1:0]  arg_a, arg_b, arg_c_in, arg_c_out;
   int                n_mismatch = 0, cmp_count = 0, cyc = 0, n_acc = 0, n_res = 0;

   lite_control_slave dut_u (.*);
   // Core and bus share one clock.
   core_model core_u (.clk, .resetn, .launch_request, .arg_b_valid, .arg_a, .arg_b,
      .accepts_new_input, .function_complete, .core_quiescent, .arg_b_read, .arg_c_out,
      .arg_c_out_valid);

   // ----------------
   // Clock, timeout and event counts
   // ----------------
   always #12.5 clk = ~clk;

   // A hang is cut short well past the roughly 130 cycles the tests need.
   always @(posedge clk)
   begin
      cyc++;
      n_acc += accepts_new_input;
      n_res += resume_request;
      if (cyc == 4000)
      begin
         n_mismatch++;
         test_done();
      end
   end

   // ----------------
   // Bus tasks
   // ----------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge clk);
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask

   task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk);
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rresp", er, s_axi_rresp);
      if (er == RESP_OKAY) chk(n, e, s_axi_rdata);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------
   // Main sequence
   // ----------------
   // One stalled run with the done interrupt, then an auto-restarted run on ready.
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd("ctrl", OFS_CTRL, 32'h4);
      rd("hole", 12'h014, 32'h0, RESP_SLVERR);
      wr(12'h014, 32'h1, RESP_SLVERR);
      wr(OFS_ARG_A, 32'h5a);
      rd("arg_a", OFS_ARG_A, 32'h5a);
      wr(OFS_ARG_B, 32'h21);
      wr(OFS_GIE, 32'h1);
      wr(OFS_IER, 32'h1);
      wr(OFS_CTRL, 32'h1);
      while (launch_request) @(posedge clk);
      rd("ctrl", OFS_CTRL, 32'h8);
      rd("ctrl", OFS_CTRL, 32'h0);
      chk("irq", 1'b0, interrupt);
      wr(OFS_B_VALID, 32'h1);
      while (interrupt !== 1'b1) @(posedge clk);
      chk("b_valid", 1'b0, arg_b_valid);
      rd("b_ack", OFS_B_ACK, 32'h1);
      rd("b_ack", OFS_B_ACK, 32'h0);
      wr(OFS_ARG_C_OUT, 32'hff);
      rd("c_out", OFS_ARG_C_OUT, 32'h7b);
      rd("c_vld", OFS_C_VALID, 32'h1);
      rd("c_vld", OFS_C_VALID, 32'h0);
      rd("isr", OFS_ISR, 32'h1);
      rd("ctrl", OFS_CTRL, 32'h6);
      chk("irq", 1'b1, interrupt);
      wr(OFS_ISR, 32'h1);
      rd("isr", OFS_ISR, 32'h0);
      chk("irq", 1'b0, interrupt);
      wr(OFS_IER, 32'h2);
      wr(OFS_ARG_C_IN, 32'h33);
      chk("c_in", 8'h33, arg_c_in);
      wr(OFS_B_VALID, 32'h1);
      wr(OFS_CTRL, 32'h81);
      while (n_acc < 2) @(posedge clk);
      rd("isr", OFS_ISR, 32'h2);
      chk("irq", 1'b1, interrupt);
      wr(OFS_CTRL, 32'h10);
      repeat (2) @(posedge clk);
      chk("resume", 1'b1, n_res > 1);
      test_done();
   end
endmodule // tb_top

// ==== rtl/arg_valid_port.sv ====
`timescale 1ns/100ps
module arg_valid_port
   import lite_ctrl_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             data_we,
   input  wire logic [ARG_W-1:0] data_in,
   input  wire logic             valid_set,
   input  wire logic             core_read,
   input  wire logic             ack_clr,
   output logic      [ARG_W-1:0] data_reg,
   output logic                  valid_reg,
   output logic                  ack_reg
);

   // Data register written by software only.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         data_reg <= ARG_RESET;
      else if (data_we)
         data_reg <= data_in;
   end

   // Valid flag: software raises it, the core consuming it drops it.
   // A software set in the consuming cycle wins, keeping the new word.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         valid_reg <= 1'b0;
      else if (valid_set)
         valid_reg <= 1'b1;
      else if (core_read)
         valid_reg <= 1'b0; // [RL3]
   end

   // Acknowledge flag records each consumption until software reads it.
   sticky_flag u_ack
   (
      .clk    (clk),
      .resetn (resetn),
      .set    (core_read & valid_reg),
      .clr    (ack_clr),
      .flag   (ack_reg)
   );

endmodule // arg_valid_port

// ==== rtl/lite_control_slave.sv ====
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
// Functional notes
// [RL1] One bundle shares one slave interface.
// [RL2] Valid port has data, ack, valid registers.
// [RL3] Core consumption clears the valid register.
// [RL4] Core stalls until valid is one.
// [RL5] Auto addresses unless explicit offset given.
// [RL6] Low range reserved for control, interrupts.
// [RL7] Return mapping gives programmable interrupt output.
// [RL8] Interrupt sources: completion and ready events.
// [RL9] Registers use the core clock by default.
// [RL10] Separate interface clock synchronous to core.
// [RL11] Interface clock no faster than core.
// [RL12] Bundle shares one clock and reset.
// [RL13] Separate interface reset is active low.
// [RL14] Only memory-style arrays; no stable inputs.
// [RL15] Avoid extra protocols; include return handshake.
// [RL16] Data path thirty-two bits wide.
// [RL17] Auto-restart starts next run on completion.
// [RL18] Software starts, resumes, reads done/idle/ready.
// [RL19] Interrupt holds until software clears pending.
module lite_control_slave
   import lite_ctrl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   // AXI4-Lite write address channel.
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   // AXI4-Lite write data channel.
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response channel.
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic      [1:0]        s_axi_bresp,
   // AXI4-Lite read address channel.
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   // AXI4-Lite read data channel.
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic      [DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   // Block-level handshake toward the core.
   output logic                   launch_request,
   output logic                   resume_request,
   input  wire logic              function_complete,
   input  wire logic              accepts_new_input,
   input  wire logic              core_quiescent,
   // Scalar argument ports toward the core.
   output logic      [ARG_W-1:0]  arg_a,
   output logic      [ARG_W-1:0]  arg_b,
   output logic                   arg_b_valid,
   input  wire logic              arg_b_read,
   output logic      [ARG_W-1:0]  arg_c_in,
   input  wire logic [ARG_W-1:0]  arg_c_out,
   input  wire logic              arg_c_out_valid,
   // Interrupt toward the processor.
   output logic                   interrupt
);

   // ----------------------------------------------------------------
   // Channel state
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      CH_IDLE = 2'b00,
      CH_RESP = 2'b01
   } chan_state_e;

   chan_state_e       wr_state_reg;
   chan_state_e       rd_state_reg;
   logic              aw_have_reg;
   logic              w_have_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [DATA_W-1:0] w_data_reg;
   logic [3:0]        w_strb_reg;
   logic [1:0]        b_resp_reg;
   logic [DATA_W-1:0] r_data_reg;
   logic [1:0]        r_resp_reg;
   logic              wr_fire;
   logic              rd_fire;
   logic              wr_hit;
   logic              wr_low;
   logic [DATA_W-1:0] rd_next;
   logic              rd_hit;

   // ----------------------------------------------------------------
   // Control and status state
   // ----------------------------------------------------------------
   logic              launch_reg;
   logic              resume_reg;
   logic              auto_restart_reg;
   logic              gie_reg;
   logic [1:0]        ier_reg;
   logic [1:0]        isr_reg;
   logic              done_flag;
   logic              ready_flag;
   logic              c_valid_flag;
   logic [ARG_W-1:0]  arg_a_reg;
   logic [ARG_W-1:0]  arg_c_in_reg;
   logic [ARG_W-1:0]  arg_c_out_reg;
   logic              b_ack;

   // Strobe decode for one write and one read.
   logic we_ctrl;
   logic we_gie;
   logic we_ier;
   logic we_isr;
   logic we_arg_a;
   logic we_arg_b;
   logic we_b_valid;
   logic we_arg_c;
   logic re_ctrl;
   logic re_b_ack;
   logic re_c_valid;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   // Address and data are taken once each, in either order.
   assign s_axi_awready = !aw_have_reg && (wr_state_reg == CH_IDLE);
   assign s_axi_wready  = !w_have_reg && (wr_state_reg == CH_IDLE);
   assign wr_fire       = aw_have_reg && w_have_reg;
   assign wr_low        = wr_fire && w_strb_reg[0];
   assign s_axi_bvalid  = (wr_state_reg == CH_RESP);
   assign s_axi_bresp   = b_resp_reg;

   // Capture the write address.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_have_reg <= 1'b0;
   end

   // Capture the write data and strobes.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_have_reg <= 1'b0;
   end

   // Write response follows the cycle both halves met.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_state_reg <= CH_IDLE;
         b_resp_reg   <= RESP_OKAY;
      end
      else
      begin
         case (wr_state_reg)
            CH_IDLE:
               if (wr_fire)
               begin
                  wr_state_reg <= CH_RESP;
                  b_resp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
               end
            CH_RESP:
               if (s_axi_bready)
                  wr_state_reg <= CH_IDLE;
            default:
               wr_state_reg <= CH_IDLE;
         endcase
      end
   end

   // Write decode: low words hold handshake and interrupt controls,
   // arguments sit above them and at their explicit offsets.
   always_comb
   begin
      we_ctrl    = 1'b0;
      we_gie     = 1'b0;
      we_ier     = 1'b0;
      we_isr     = 1'b0;
      we_arg_a   = 1'b0;
      we_arg_b   = 1'b0;
      we_b_valid = 1'b0;
      we_arg_c   = 1'b0;
      wr_hit     = 1'b1;
      if (aw_addr_reg == OFS_CTRL)
         we_ctrl = wr_low; // [RL6]
      else if (aw_addr_reg == OFS_GIE)
         we_gie = wr_low;
      else if (aw_addr_reg == OFS_IER)
         we_ier = wr_low;
      else if (aw_addr_reg == OFS_ISR)
         we_isr = wr_low;
      else if (aw_addr_reg == OFS_ARG_A)
         we_arg_a = wr_low; // [RL5]
      else if (aw_addr_reg == OFS_ARG_B)
         we_arg_b = wr_low; // [RL2]
      else if (aw_addr_reg == OFS_B_VALID)
         we_b_valid = wr_low && w_data_reg[0];
      else if (aw_addr_reg == OFS_ARG_C_IN)
         we_arg_c = wr_low; // [RL5]
      else if (aw_addr_reg == OFS_B_ACK || aw_addr_reg == OFS_ARG_C_OUT
               || aw_addr_reg == OFS_C_VALID)
         wr_hit = 1'b1;
      else
         wr_hit = 1'b0;
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   // One read at a time; the address is taken only while idle.
   assign s_axi_arready = (rd_state_reg == CH_IDLE);
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign s_axi_rvalid  = (rd_state_reg == CH_RESP);
   assign s_axi_rdata   = r_data_reg;
   assign s_axi_rresp   = r_resp_reg;

   // Read mux over the one shared bundle, 32-bit words. [RL1]
   always_comb
   begin
      rd_next    = '0; // [RL16]
      rd_hit     = 1'b1;
      re_ctrl    = 1'b0;
      re_b_ack   = 1'b0;
      re_c_valid = 1'b0;
      if (s_axi_araddr == OFS_CTRL)
      begin
         rd_next[CTRL_LAUNCH] = launch_reg; // [RL18]
         rd_next[CTRL_DONE]   = done_flag;
         rd_next[CTRL_IDLE]   = core_quiescent;
         rd_next[CTRL_READY]  = ready_flag;
         rd_next[CTRL_AUTO]   = auto_restart_reg;
         re_ctrl              = rd_fire;
      end
      else if (s_axi_araddr == OFS_GIE)
         rd_next[0] = gie_reg;
      else if (s_axi_araddr == OFS_IER)
         rd_next[1:0] = ier_reg;
      else if (s_axi_araddr == OFS_ISR)
         rd_next[1:0] = isr_reg;
      else if (s_axi_araddr == OFS_ARG_A)
         rd_next[ARG_W-1:0] = arg_a_reg;
      else if (s_axi_araddr == OFS_ARG_B)
         rd_next[ARG_W-1:0] = arg_b;
      else if (s_axi_araddr == OFS_B_VALID)
         rd_next[0] = arg_b_valid;
      else if (s_axi_araddr == OFS_B_ACK)
      begin
         rd_next[0] = b_ack; // [RL2]
         re_b_ack   = rd_fire;
      end
      else if (s_axi_araddr == OFS_ARG_C_IN)
         rd_next[ARG_W-1:0] = arg_c_in_reg;
      else if (s_axi_araddr == OFS_ARG_C_OUT)
         rd_next[ARG_W-1:0] = arg_c_out_reg;
      else if (s_axi_araddr == OFS_C_VALID)
      begin
         rd_next[0] = c_valid_flag;
         re_c_valid = rd_fire;
      end
      else
         rd_hit = 1'b0;
   end

   // Read data is registered and holds until the master takes it.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_state_reg <= CH_IDLE;
         r_data_reg   <= '0;
         r_resp_reg   <= RESP_OKAY;
      end
      else
      begin
         case (rd_state_reg)
            CH_IDLE:
               if (rd_fire)
               begin
                  rd_state_reg <= CH_RESP;
                  r_data_reg   <= rd_next;
                  r_resp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
               end
            CH_RESP:
               if (s_axi_rready)
                  rd_state_reg <= CH_IDLE;
            default:
               rd_state_reg <= CH_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Block-level handshake
   // ----------------------------------------------------------------
   // Launch holds until the core accepts input; auto-restart
   // keeps it up for the next run.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         launch_reg <= 1'b0; // [RL15]
      else if (we_ctrl && w_data_reg[CTRL_LAUNCH])
         launch_reg <= 1'b1; // [RL18]
      else if (auto_restart_reg && function_complete)
         launch_reg <= 1'b1; // [RL17]
      else if (accepts_new_input && !auto_restart_reg)
         launch_reg <= 1'b0;
   end

   // Resume pulses once per write; auto-restart also resumes
   // so a finished run never blocks the next.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         resume_reg <= 1'b0;
      else
         resume_reg <= (we_ctrl && w_data_reg[CTRL_RESUME])
                       || (auto_restart_reg && function_complete); // [RL17]
   end

   // Auto-restart setting.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         auto_restart_reg <= 1'b0;
      else if (we_ctrl)
         auto_restart_reg <= w_data_reg[CTRL_AUTO]; // [RL17]
   end

   // Done and ready are caught as they pulse and cleared by
   // reading the control word, so no pulse is missed.
   sticky_flag u_done
   (
      .clk    (clk),
      .resetn (resetn),
      .set    (function_complete),
      .clr    (re_ctrl),
      .flag   (done_flag)
   );

   sticky_flag u_ready
   (
      .clk    (clk),
      .resetn (resetn),
      .set    (accepts_new_input),
      .clr    (re_ctrl),
      .flag   (ready_flag)
   );

   assign launch_request = launch_reg;
   assign resume_request = resume_reg;

   // ----------------------------------------------------------------
   // Interrupt control
   // ----------------------------------------------------------------
   // Global enable and per-source enable.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gie_reg <= 1'b0;
         ier_reg <= IRQ_RESET;
      end
      else
      begin
         if (we_gie)
            gie_reg <= w_data_reg[0]; // [RL7]
         if (we_ier)
            ier_reg <= w_data_reg[1:0];
      end
   end

   // Pending bits latch enabled events; writing one clears a bit,
   // but a new event in that cycle keeps it pending.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_isr
         logic src;
         assign src = (gi == IRQ_DONE) ? function_complete
                                       : accepts_new_input; // [RL8]
         sticky_flag u_isr
         (
            .clk    (clk),
            .resetn (resetn),
            .set    (src && ier_reg[gi]),
            .clr    (we_isr && w_data_reg[gi]), // [RL19]
            .flag   (isr_reg[gi])
         );
      end
   endgenerate

   // Registered so the output is clean of decode glitches.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         interrupt <= 1'b0;
      else
         interrupt <= gie_reg && (|isr_reg); // [RL19]
   end

   // ----------------------------------------------------------------
   // Argument registers
   // ----------------------------------------------------------------
   // Plain scalars only, no arrays; one clock and one low reset.
   // [RL14] [RL13]
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         arg_a_reg    <= ARG_RESET; // [RL9] [RL12]
         arg_c_in_reg <= ARG_RESET;
      end
      else
      begin
         if (we_arg_a)
            arg_a_reg <= w_data_reg[ARG_W-1:0];
         if (we_arg_c)
            arg_c_in_reg <= w_data_reg[ARG_W-1:0];
      end
   end

   // Output of argument c is captured when the core marks it valid.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         arg_c_out_reg <= ARG_RESET;
      else if (arg_c_out_valid)
         arg_c_out_reg <= arg_c_out;
   end

   sticky_flag u_c_valid
   (
      .clk    (clk),
      .resetn (resetn),
      .set    (arg_c_out_valid),
      .clr    (re_c_valid),
      .flag   (c_valid_flag)
   );

   // Valid-qualified input b; the core must hold off while it is low.
   arg_valid_port u_arg_b
   (
      .clk       (clk),
      .resetn    (resetn),
      .data_we   (we_arg_b),
      .data_in   (w_data_reg[ARG_W-1:0]),
      .valid_set (we_b_valid), // [RL4]
      .core_read (arg_b_read),
      .ack_clr   (re_b_ack),
      .data_reg  (arg_b),
      .valid_reg (arg_b_valid),
      .ack_reg   (b_ack)
   );

   assign arg_a    = arg_a_reg;
   assign arg_c_in = arg_c_in_reg;

endmodule // lite_control_slave

// ==== rtl/lite_ctrl_pkg.sv ====
package lite_ctrl_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int ARG_W  = 8;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_GIE       = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_IER       = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_ISR       = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_ARG_A     = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_ARG_B     = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_B_VALID   = 12'h01c;
   localparam logic [ADDR_W-1:0] OFS_B_ACK     = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_ARG_C_IN  = 12'h400;
   localparam logic [ADDR_W-1:0] OFS_ARG_C_OUT = 12'h408;
   localparam logic [ADDR_W-1:0] OFS_C_VALID   = 12'h40c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_LAUNCH = 0;
   localparam int CTRL_DONE   = 1;
   localparam int CTRL_IDLE   = 2;
   localparam int CTRL_READY  = 3;
   localparam int CTRL_RESUME = 4;
   localparam int CTRL_AUTO   = 7;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_READY   = 1;

   // ----------------------------------------------------------------
   // Reset values and responses
   // ----------------------------------------------------------------
   localparam logic [ARG_W-1:0] ARG_RESET  = 8'h00;
   localparam logic [1:0]       IRQ_RESET  = 2'h0;
   localparam logic [1:0]       RESP_OKAY  = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/sticky_flag.sv ====
`timescale 1ns/100ps
module sticky_flag
   import lite_ctrl_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag
);

   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flag <= 1'b0;
      else if (set)
         flag <= 1'b1;
      else if (clr)
         flag <= 1'b0;
   end

endmodule // sticky_flag
